// *** hdl/icfl_defs.svh ***
// register map, field positions, reset values and timing counts of the change-flag block
`ifndef ICFL_DEFS_SVH
`define ICFL_DEFS_SVH

// ****************************************************************
// register word indices (byte address is four times the index)
// ****************************************************************
`define ICFL_IDX_MISC       4'h0
`define ICFL_IDX_FLAGS      4'h1
`define ICFL_IDX_MASK       4'h2
`define ICFL_IDX_VALID      4'h3

// ****************************************************************
// field positions
// ****************************************************************
`define ICFL_BIT_RESYNC     3'd4
`define ICFL_BIT_EDGE       3'd2
`define ICFL_MISC_WMASK     8'h1F

// ****************************************************************
// reset values
// ****************************************************************
`define ICFL_RST_MISC       8'h14
`define ICFL_RST_FLAGS      8'hFF
`define ICFL_RST_MASK       8'h00

// ****************************************************************
// timing
// ****************************************************************
`define ICFL_CLK_HZ         20000000
`define ICFL_PWRUP_SYNC_S   2

`endif

// *** hdl/icfl_pkg.sv ***
// shared types of the change-flag block
package icfl_pkg;

    typedef struct packed {
        logic       en;
        logic [3:0] idx;
        logic [7:0] data;
    } icfl_regwr_type;

    typedef struct packed {
        logic [1:0]  htrans;
        logic [31:0] haddr;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hsel;
    } icfl_ahbreq_type;

    typedef enum logic [1:0] {
        ICFL_PH_IDLE,
        ICFL_PH_WRITE,
        ICFL_PH_READ
    } icfl_phase_type;

endpackage : icfl_pkg

// *** hdl/icfl_ahb_slave.sv ***
// AHB-Lite slave front end of the change-flag block
module icfl_ahb_slave (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire icfl_pkg::icfl_ahbreq_type req,
    input  wire logic                     hready,
    input  wire logic [31:0]              hwdata,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    output icfl_pkg::icfl_regwr_type      regWr,
    output logic [3:0]                    rdIdx,
    input  wire logic [7:0]               rdData
);
    import icfl_pkg::*;

    typedef struct packed {
        icfl_phase_type phase;
        logic [3:0]     idx;
        logic           mapped;
        logic           ready;
        logic [31:0]    rdata;
    } icfl_slv_type;

    icfl_slv_type st_q;
    icfl_slv_type st_d;

    // ****************************************************************
    // transfer sequencing
    // ****************************************************************
    // reads take one wait state so a write committing in the same cycle is seen
    always_comb begin
        st_d = st_q;
        case (st_q.phase)
            ICFL_PH_READ: begin
                st_d.rdata = st_q.mapped ? {24'h000000, rdData} : 32'h00000000;
                st_d.ready = 1'b1;
                st_d.phase = ICFL_PH_IDLE;
            end
            ICFL_PH_IDLE, ICFL_PH_WRITE: begin
                st_d.phase = ICFL_PH_IDLE;
                if (req.hsel && req.htrans[1] && hready) begin
                    st_d.idx    = req.haddr[5:2];
                    st_d.mapped = (req.haddr[31:6] == 26'h0000000);
                    if (req.hwrite) begin
                        st_d.phase = ICFL_PH_WRITE;
                    end else begin
                        st_d.phase = ICFL_PH_READ;
                        st_d.ready = 1'b0;
                    end
                end
            end
            default: begin
                st_d.phase = ICFL_PH_IDLE;
                st_d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '{phase: ICFL_PH_IDLE, idx: 4'h0, mapped: 1'b0, ready: 1'b1,
                      rdata: 32'h00000000};
        end else begin
            st_q <= st_d;
        end
    end

    assign hreadyout  = st_q.ready;
    assign hresp      = 1'b0;
    assign hrdata     = st_q.rdata;
    assign rdIdx      = st_q.idx;
    assign regWr.en   = (st_q.phase == ICFL_PH_WRITE) && st_q.mapped;
    assign regWr.idx  = st_q.idx;
    assign regWr.data = hwdata[7:0];

endmodule : icfl_ahb_slave

// *** hdl/icfl_top.sv ***
// input change flag latches with divider resync and frame edge controls
// Functional notes
// RL1: with analog resync off the analog divider is aligned only for 2 s after power-up, with it on it stays aligned always.
// RL2: on an 8 kHz current input the lock edge is falling when the edge select is 0 and rising when it is 1.
// RL3: each low flag bit latches to 1 when its reference input changes validity, bit 7 for input eight down to bit 0 for input one.
// RL4: writing 1 to a flag bit clears it to 0, and a 0 means no validity change has been seen.
// RL5: software writes test bits 3, 1 and 0 as zero or leaves them, and unused bit 5 reads as zero.
`include "icfl_defs.svh"

module icfl_top #(
    parameter int unsigned NUM_INPUTS        = 8,
    parameter int unsigned PWRUP_SYNC_CYCLES = `ICFL_PWRUP_SYNC_S * `ICFL_CLK_HZ
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire icfl_pkg::icfl_ahbreq_type ahbReq,
    input  wire logic                     hready,
    input  wire logic [31:0]              hwdata,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    input  wire logic [NUM_INPUTS-1:0]    refValid,
    input  wire logic                     frameRefClk,
    input  wire logic                     frameRefIs8k,
    output logic                          irq,
    output logic                          analogAlignEn,
    output logic                          frameLockPulse
);
    import icfl_pkg::*;

    localparam int CNT_W = $clog2(PWRUP_SYNC_CYCLES + 1);

    if (NUM_INPUTS != 8) begin : g_chk_inputs
        $error("icfl_top: the flag register holds exactly eight inputs");
    end
    if (PWRUP_SYNC_CYCLES < 1) begin : g_chk_sync
        $error("icfl_top: power-up align window must be at least one cycle");
    end

    typedef struct packed {
        logic [7:0]       validMeta;
        logic [7:0]       validSync;
        logic [7:0]       validPrev;
        logic [2:0]       refPipe;
        logic [2:0]       refFill;
        logic [7:0]       misc;
        logic [7:0]       flags;
        logic [7:0]       mask;
        logic [CNT_W-1:0] upCnt;
        logic             irq;
        logic             align;
        logic             frameLock;
    } icfl_core_type;

    icfl_core_type  st_q;
    icfl_core_type  st_d;
    icfl_regwr_type regWr;
    logic [3:0]     rdIdx;
    logic [7:0]     rdData;
    logic [7:0]     chg;
    logic [7:0]     clrVec;
    logic [7:0]     keepVec;
    logic           refRise;
    logic           refFall;
    logic           upWindow;

    function automatic logic hits(input icfl_regwr_type w, input logic [3:0] idx);
        hits = w.en && (w.idx == idx);
    endfunction : hits

    // ****************************************************************
    // bus front end
    // ****************************************************************
    icfl_ahb_slave u_slave (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .req       (ahbReq),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .regWr     (regWr),
        .rdIdx     (rdIdx),
        .rdData    (rdData)
    );

    // ****************************************************************
    // event and edge detection
    // ****************************************************************
    assign chg      = st_q.validSync ^ st_q.validPrev; // RL3
    assign clrVec   = hits(regWr, `ICFL_IDX_FLAGS) ? regWr.data : 8'h00; // RL4
    assign keepVec  = st_q.flags & ~clrVec;
    // no edge until three real samples are in, else a high pin fakes a rise after reset
    assign refRise  = st_q.refPipe[1] & ~st_q.refPipe[2] & st_q.refFill[2];
    assign refFall  = ~st_q.refPipe[1] & st_q.refPipe[2] & st_q.refFill[2];
    assign upWindow = (st_q.upCnt < CNT_W'(PWRUP_SYNC_CYCLES));

    always_comb begin
        case (rdIdx)
            // bits 7 to 5 are not held here and read as zero
            `ICFL_IDX_MISC:  rdData = st_q.misc & `ICFL_MISC_WMASK; // RL5
            `ICFL_IDX_FLAGS: rdData = st_q.flags;
            `ICFL_IDX_MASK:  rdData = st_q.mask;
            `ICFL_IDX_VALID: rdData = st_q.validSync;
            default:         rdData = 8'h00;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        // first stage feeds only the second stage
        st_d.validMeta = refValid;
        st_d.validSync = st_q.validMeta;
        st_d.validPrev = st_q.validSync;
        st_d.refPipe   = {st_q.refPipe[1:0], frameRefClk};
        st_d.refFill   = {st_q.refFill[1:0], 1'b1};
        if (hits(regWr, `ICFL_IDX_MISC)) begin
            // test bits are stored as written, software keeps them at zero
            st_d.misc = regWr.data & `ICFL_MISC_WMASK;
        end
        if (hits(regWr, `ICFL_IDX_MASK)) begin
            st_d.mask = regWr.data;
        end
        // a change in the clearing cycle wins over the clear
        st_d.flags = keepVec | chg; // RL3 RL4
        st_d.irq   = |(st_d.flags & st_d.mask);
        // counter stops at the window end, so it never wraps back into it
        if (upWindow) begin
            st_d.upCnt = st_q.upCnt + CNT_W'(1);
        end
        st_d.align = st_q.misc[`ICFL_BIT_RESYNC] | upWindow; // RL1
        // mode flag comes from logic on this clock, so it is not synchronised
        st_d.frameLock = frameRefIs8k &
                         (st_q.misc[`ICFL_BIT_EDGE] ? refRise : refFall); // RL2
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '{validMeta: 8'h00, validSync: 8'h00, validPrev: 8'h00,
                      refPipe: 3'b000, refFill: 3'b000, misc: `ICFL_RST_MISC,
                      flags: `ICFL_RST_FLAGS,
                      mask: `ICFL_RST_MASK, upCnt: '0, irq: 1'b0, align: 1'b1,
                      frameLock: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign irq            = st_q.irq;
    assign analogAlignEn  = st_q.align;
    assign frameLockPulse = st_q.frameLock;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence fallOnSelZero;
        frameRefIs8k && !st_q.misc[`ICFL_BIT_EDGE] && refFall;
    endsequence

    sequence riseOnSelOne;
        frameRefIs8k && st_q.misc[`ICFL_BIT_EDGE] && refRise;
    endsequence

    sequence validToggle;
        (refValid != st_q.validMeta) ##2 (|chg);
    endsequence

    a_change_sets_flag: assert property ((|chg) |=> ((st_q.flags & $past(chg)) == $past(chg))) // RL3
        else $error("validity change did not latch its flag");

    a_flag_stays_set: assert property (1'b1 |=> ((st_q.flags & $past(keepVec)) == $past(keepVec))) // RL3
        else $error("set flag dropped without a clear");

    a_pin_to_flag: assert property (validToggle |=> (st_q.flags != 8'h00)) // RL3
        else $error("synchronised change did not reach flags");

    a_clear_by_one: assert property ((|clrVec) |=> ((st_q.flags & $past(clrVec & ~chg)) == 8'h00)) // RL4
        else $error("write of one did not clear the flag");

    a_falling_lock: assert property (fallOnSelZero |=> frameLockPulse) // RL2
        else $error("falling edge lock missed");

    a_rising_lock: assert property (riseOnSelOne |=> frameLockPulse) // RL2
        else $error("rising edge lock missed");

    a_wrong_edge: assert property ((frameLockPulse && !$past(st_q.misc[`ICFL_BIT_EDGE]))
                                   |-> $past(refFall)) // RL2
        else $error("lock pulse on unselected edge");

    a_align_window: assert property ((!st_q.misc[`ICFL_BIT_RESYNC] && !upWindow)
                                     |=> !analogAlignEn) // RL1
        else $error("analog align held past power-up window");

    a_align_resync: assert property (st_q.misc[`ICFL_BIT_RESYNC] |=> analogAlignEn) // RL1
        else $error("analog align dropped while resync is on");

    a_irq_level: assert property ((|(st_q.flags & st_q.mask)) |-> irq)
        else $error("interrupt low with unmasked flag set");

    a_irq_quiet: assert property ((!(|(st_q.flags & st_q.mask))) |-> !irq)
        else $error("interrupt high with no unmasked flag");

    a_rising_only: assert property ((frameLockPulse && $past(st_q.misc[`ICFL_BIT_EDGE]))
                                    |-> $past(refRise)) // RL2
        else $error("lock pulse without a rising edge");

    a_lock_needs_8k: assert property (!frameRefIs8k |=> !frameLockPulse) // RL2
        else $error("lock pulse while current input is not 8 kHz");

    a_window_ends: assert property (!upWindow |=> !upWindow) // RL1
        else $error("power-up align window reopened");

    a_misc_read_zero: assert property ((rdIdx == `ICFL_IDX_MISC)
                                       |-> (rdData[7:5] == 3'b000)) // RL5
        else $error("unused control bits read as one");

    a_mask_write: assert property (hits(regWr, `ICFL_IDX_MASK)
                                   |=> (st_q.mask == $past(regWr.data)))
        else $error("mask write not stored");

endmodule : icfl_top

// *** sim/icfl_top_tb_top.sv ***
// self-checking bench of the change-flag block
`include "icfl_defs.svh"

module icfl_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import icfl_pkg::*;

    logic            clk;
    logic            sysRst;
    icfl_ahbreq_type ahbReq;
    logic [31:0]     hwdata;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic [7:0]      refValid;
    logic            frameRefClk;
    logic            frameRefIs8k;
    logic            irq;
    logic            analogAlignEn;
    logic            frameLockPulse;
    logic            rdPh;
    logic            irqSeen;
    logic            alignSeen;
    logic            pulseSeen;
    logic [7:0]      expQ[$];
    logic [31:0]     seed;
    int              error_cnt;
    int              comparisons;

    icfl_top #(.NUM_INPUTS(8), .PWRUP_SYNC_CYCLES(20)) dut (
        .clk(clk), .sys_rst(sysRst), .ahbReq(ahbReq), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .refValid(refValid),
        .frameRefClk(frameRefClk), .frameRefIs8k(frameRefIs8k), .irq(irq),
        .analogAlignEn(analogAlignEn), .frameLockPulse(frameLockPulse)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************************************
    // observation
    // ****************************************************************
    // levels copied at the falling edge so checks at the rising edge never race
    always @(negedge clk) begin
        irqSeen   <= irq;
        alignSeen <= analogAlignEn;
        pulseSeen <= frameLockPulse;
        if (rdPh && hreadyout === 1'b1) begin
            chk(hrdata, {24'h0, expQ.pop_front()});
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // ****************************************************************
    // bus master
    // ****************************************************************
    task automatic waitRdy;
        int   n;
        logic r;
        n = 0;
        do begin
            @(negedge clk);
            r = hreadyout;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 20);
        if (r !== 1'b1) begin
            error_cnt++;
            $display("FAIL %0t bus timeout", $time);
            stop_test();
        end
    endtask : waitRdy

    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
        ahbReq <= '{htrans: 2'h2, haddr: {26'h0, idx, 2'h0}, hwrite: wr, hsize: 3'h2, hsel: 1'b1};
        waitRdy();
        ahbReq <= '{htrans: 2'h0, haddr: 32'h0, hwrite: 1'b0, hsize: 3'h2, hsel: 1'b0};
        hwdata <= {24'h0, d};
        rdPh = !wr;
        waitRdy();
        rdPh = 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        expQ.push_back(exp);
        bus(1'b0, idx, 8'h00);
    endtask : rd

    task automatic flip(input logic [7:0] p);
        refValid <= refValid ^ p;
        repeat (6) @(posedge clk);
    endtask : flip

    task automatic edgeTry(input logic lvl, input logic exp);
        logic seen;
        seen = 1'b0;
        frameRefClk <= lvl;
        repeat (8) begin
            @(posedge clk);
            seen |= pulseSeen;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask : edgeTry

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [7:0] p;
        sysRst = 1'b1; ahbReq = '0; hwdata = '0; refValid = '0; rdPh = 1'b0;
        frameRefClk = 1'b0; frameRefIs8k = 1'b1; error_cnt = 0; comparisons = 0;
        seed = 32'h2F0BC317;
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        rd(`ICFL_IDX_MISC, 8'h14);
        rd(`ICFL_IDX_FLAGS, 8'hFF);
        rd(`ICFL_IDX_MASK, 8'h00);
        bus(1'b1, `ICFL_IDX_MISC, 8'h00);
        repeat (2) @(posedge clk);
        chk(alignSeen, 1'b1);
        repeat (25) @(posedge clk);
        chk(alignSeen, 1'b0);
        bus(1'b1, `ICFL_IDX_MISC, 8'hE4);
        rd(`ICFL_IDX_MISC, 8'h04);
        chk(alignSeen, 1'b0);
        bus(1'b1, `ICFL_IDX_MISC, 8'h10);
        repeat (2) @(posedge clk);
        chk(alignSeen, 1'b1);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            bus(1'b1, `ICFL_IDX_MISC, seed[7:0] & 8'hF4);
            rd(`ICFL_IDX_MISC, seed[7:0] & 8'h14);
            bus(1'b1, `ICFL_IDX_MASK, seed[15:8]);
            rd(`ICFL_IDX_MASK, seed[15:8]);
        end
        bus(1'b1, `ICFL_IDX_MASK, 8'h00);
        bus(1'b1, `ICFL_IDX_FLAGS, 8'hFF);
        rd(`ICFL_IDX_FLAGS, 8'h00);
        // single inputs first, then random groups of inputs
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            p = (i < 8) ? (8'h01 << i) : seed[7:0];
            flip(p);
            rd(`ICFL_IDX_FLAGS, p);
            bus(1'b1, `ICFL_IDX_FLAGS, p);
            rd(`ICFL_IDX_FLAGS, 8'h00);
            rd(`ICFL_IDX_VALID, refValid);
        end
        flip(8'hC3);
        bus(1'b1, `ICFL_IDX_FLAGS, 8'h41);
        rd(`ICFL_IDX_FLAGS, 8'h82);
        bus(1'b1, `ICFL_IDX_FLAGS, 8'hFF);
        flip(8'h01);
        chk(irqSeen, 1'b0);
        bus(1'b1, `ICFL_IDX_MASK, 8'h01);
        repeat (2) @(posedge clk);
        chk(irqSeen, 1'b1);
        bus(1'b1, `ICFL_IDX_MASK, 8'h02);
        repeat (2) @(posedge clk);
        chk(irqSeen, 1'b0);
        bus(1'b1, `ICFL_IDX_MASK, 8'h01);
        bus(1'b1, `ICFL_IDX_FLAGS, 8'h01);
        repeat (2) @(posedge clk);
        chk(irqSeen, 1'b0);
        bus(1'b1, 4'h5, 8'hFF);
        rd(4'h5, 8'h00);
        bus(1'b1, `ICFL_IDX_VALID, 8'hFF);
        rd(`ICFL_IDX_VALID, refValid);
        bus(1'b1, `ICFL_IDX_MISC, 8'h10);
        edgeTry(1'b1, 1'b0);
        edgeTry(1'b0, 1'b1);
        bus(1'b1, `ICFL_IDX_MISC, 8'h14);
        edgeTry(1'b1, 1'b1);
        edgeTry(1'b0, 1'b0);
        frameRefIs8k <= 1'b0;
        edgeTry(1'b1, 1'b0);
        // reset in mid-run with the frame pin held high and rising edge selected
        frameRefIs8k <= 1'b1;
        bus(1'b1, `ICFL_IDX_MASK, 8'hFF);
        flip(8'h01);
        chk(irqSeen, 1'b1);
        sysRst <= 1'b1;
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        edgeTry(1'b1, 1'b0);
        chk(irqSeen, 1'b0);
        rd(`ICFL_IDX_MISC, 8'h14);
        rd(`ICFL_IDX_FLAGS, 8'hFF);
        rd(`ICFL_IDX_MASK, 8'h00);
        stop_test();
    end
endmodule : icfl_top_tb_top
